// *** wwd_map.svh ***
// Register map, field positions, reset values and timing counts of the windowed watchdog
// Behaviour
// - A 12-bit down counter loads the reload value and counts toward zero while running.
// - The counter steps once per prescaler tick; the prescaler divides slow ticks by 128.
// - After reset the reload value is 0xFFF and fault reset enable is 1.
// - The mode register takes only its first write after reset; reads always allowed.
// - An accepted mode write reloads the counter and restarts counting like a restart.
// - Restart bit 1 with key 0xA5 inside the window reloads the counter and clears the prescaler.
// - A control write with a wrong key is discarded with no effect at all.
// - Underflow sets the sticky underflow flag and raises the fault line if reset enabled.
// - A keyed restart reloads only when the counter is at or below the delta.
// - A restart outside the window sets the error flag, and fault if reset enabled, even when disabled.
// - With delta at or above reload, restarts are accepted at any counter value.
// - The interrupt is high while either flag is set and fault interrupt enable is 1.
// - Reset enable 0 keeps faults off resets; else select picks cpu-only or all resets.
// - A watchdog reset resets the watchdog itself and clears both flags.
// - A status read or any reset clears both flags, the interrupt and the fault line.
// - Each flag is sticky: 1 if one such event happened since the last status read.
// - Disable bit 1 stops the counter; 0 lets it run.
// - Debug halt enable 1 stops the counter while the processor is in debug state.
// - Idle halt enable 1 stops the counter while the system is idle.
// - Mode layout: reload 11:0, irq en 12, rst en 13, cpu sel 14, dis 15, delta 27:16, 28, 29.
`ifndef WWD_MAP_SVH
`define WWD_MAP_SVH

// Register byte offsets
`define WWD_OFS_CONTROL    8'h00
`define WWD_OFS_MODE       8'h04
`define WWD_OFS_STATUS     8'h08

// Mode register fields
`define WWD_RELOAD_LSB     0
`define WWD_RELOAD_MSB     11
`define WWD_FIEN_BIT       12
`define WWD_RSTEN_BIT      13
`define WWD_CPUSEL_BIT     14
`define WWD_DIS_BIT        15
`define WWD_DELTA_LSB      16
`define WWD_DELTA_MSB      27
`define WWD_DBGHLT_BIT     28
`define WWD_IDLEHLT_BIT    29
`define WWD_MODE_RESET     32'h3FFF2FFF
`define WWD_MODE_WMASK     32'h3FFFFFFF

// Control register fields
`define WWD_RESTART_BIT    0
`define WWD_KEY_LSB        24
`define WWD_KEY_MSB        31
`define WWD_KEY_VALUE      8'hA5

// Status register fields
`define WWD_UNF_BIT        0
`define WWD_ERR_BIT        1

// Timing counts
`define WWD_PRESCALE_DIV   128
`define WWD_CNT_WIDTH      12

// Bus answers
`define WWD_RESP_OKAY      2'h0
`define WWD_RESP_SLVERR    2'h2

`endif

// *** wwd_pkg.sv ***
// Types shared by the windowed watchdog modules
`default_nettype none
package wwd_pkg;
    // Outcome of a keyed restart request
    typedef enum logic [1:0] {
        WWD_RS_NONE,
        WWD_RS_RELOAD,
        WWD_RS_ERROR
    } wwd_restart_t;
    typedef logic [11:0] wwd_count_t;
endpackage
`default_nettype wire

// *** wwd_presc.sv ***
// Slow clock prescaler producing one counter step every DIV slow ticks
`default_nettype none
module wwd_presc #(
    parameter int DIV = 128
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic clr,
    input  wire logic en,
    // Step out
    output logic      step
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    generate
        if (DIV < 2) begin : g_bad_div
            $error("wwd_presc: DIV must be at least 2");
        end
    endgenerate

    logic [CW-1:0] cnt_reg;

    // Last slow tick of a period gives the step
    assign step = en && !clr && (cnt_reg == CW'(DIV - 1));

    // Divider count, cleared by restarts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (clr) begin
            cnt_reg <= '0;
        end else if (step) begin
            cnt_reg <= '0;
        end else if (en) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** wwd_axil.sv ***
// AXI4-Lite slave front end: one write and one read under way at a time
`include "wwd_map.svh"
`default_nettype none
module wwd_axil #(
    parameter int AW = 8
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Write address and data
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          wvalid,
    output logic               wready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    // Write response
    output logic               bvalid,
    input  wire logic          bready,
    output logic [1:0]         bresp,
    // Read address and data
    input  wire logic          arvalid,
    output logic               arready,
    input  wire logic [AW-1:0] araddr,
    output logic               rvalid,
    input  wire logic          rready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    // Core side
    output logic               wr_en,
    output logic [AW-1:0]      wr_addr,
    output logic [31:0]        wr_data,
    output logic [3:0]         wr_strb,
    input  wire logic          wr_err,
    output logic               rd_en,
    output logic [AW-1:0]      rd_addr,
    input  wire logic [31:0]   rd_data,
    input  wire logic          rd_err
);
    logic aw_full_reg;
    logic w_full_reg;

    // Core strobes
    assign wr_en   = aw_full_reg && w_full_reg && !bvalid;
    assign rd_en   = arvalid && arready;
    assign rd_addr = araddr;

    // Write address capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready     <= 1'b1;
            aw_full_reg <= 1'b0;
            wr_addr     <= '0;
        end else if (awvalid && awready) begin
            awready     <= 1'b0;
            aw_full_reg <= 1'b1;
            wr_addr     <= awaddr;
        end else if (wr_en) begin
            aw_full_reg <= 1'b0;
        end else if (bvalid && bready) begin
            awready     <= 1'b1;
        end
    end

    // Write data capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wready     <= 1'b1;
            w_full_reg <= 1'b0;
            wr_data    <= '0;
            wr_strb    <= '0;
        end else if (wvalid && wready) begin
            wready     <= 1'b0;
            w_full_reg <= 1'b1;
            wr_data    <= wdata;
            wr_strb    <= wstrb;
        end else if (wr_en) begin
            w_full_reg <= 1'b0;
        end else if (bvalid && bready) begin
            wready     <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= `WWD_RESP_OKAY;
        end else if (wr_en) begin
            bvalid <= 1'b1;
            bresp  <= wr_err ? `WWD_RESP_SLVERR : `WWD_RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `WWD_RESP_OKAY;
        end else if (rd_en) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_data;
            rresp   <= rd_err ? `WWD_RESP_SLVERR : `WWD_RESP_OKAY;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** wwd_top.sv ***
// Windowed watchdog timer core with AXI4-Lite register access
//
// Implementation choice: the AXI4-Lite slave port.
`include "wwd_map.svh"
`default_nettype none
module wwd_top #(
    parameter int PRESCALE_DIV = `WWD_PRESCALE_DIV,
    parameter int CNT_W        = `WWD_CNT_WIDTH
) (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // Slow clock tick, one cycle per slow clock period
    input  wire logic        SLOW_TICK,
    // Processor and system state
    input  wire logic        CPU_DEBUG,
    input  wire logic        SYS_IDLE,
    // AXI4-Lite write address
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [7:0]  S_AXI_AWADDR,
    // AXI4-Lite write data
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    // AXI4-Lite write response
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output logic [1:0]       S_AXI_BRESP,
    // AXI4-Lite read address
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    // AXI4-Lite read data
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    // Fault signalling to the reset controller and interrupt
    output logic             WDT_FAULT,
    output logic             WDT_FAULT_CPU_ONLY,
    output logic             WDT_IRQ
);
    // The mode register layout holds exactly a 12-bit count
    generate
        if (CNT_W != `WWD_CNT_WIDTH) begin : g_bad_width
            $error("wwd_top: CNT_W must match the 12-bit reload field");
        end
        if (PRESCALE_DIV < 2) begin : g_bad_div
            $error("wwd_top: PRESCALE_DIV must be at least 2");
        end
    endgenerate

    // Word indices of the registers, matched against address bits 7:2
    localparam logic [5:0] idx_control = 6'(`WWD_OFS_CONTROL >> 2);
    localparam logic [5:0] idx_mode    = 6'(`WWD_OFS_MODE >> 2);
    localparam logic [5:0] idx_status  = 6'(`WWD_OFS_STATUS >> 2);

    // Bus side strobes
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;

    // Stored state
    logic [31:0]         mode_reg;
    logic                mode_locked_reg;
    wwd_pkg::wwd_count_t count_reg;
    logic                underflow_flag_reg;
    logic                window_error_flag_reg;

    // Next values
    logic [31:0]         mode_next;
    wwd_pkg::wwd_count_t count_next;
    logic                underflow_flag_next;
    logic                window_error_flag_next;

    // Decoded fields of the mode register
    wwd_pkg::wwd_count_t reload_value;
    wwd_pkg::wwd_count_t window_delta;
    logic                fault_irq_enable;
    logic                fault_reset_enable;
    logic                cpu_only_reset_select;
    logic                guard_disable;
    logic                debug_halt_enable;
    logic                idle_halt_enable;

    // Decoded accesses and events
    logic                     ctrl_wr;
    logic                     mode_wr;
    logic                     status_rd;
    logic                     key_ok;
    logic                     restart_cmd;
    logic                     window_open;
    wwd_pkg::wwd_restart_t    restart_kind;
    logic                     reload_now;
    wwd_pkg::wwd_count_t      reload_src;
    logic                     halted;
    logic                     running;
    logic                     step;
    logic                     underflow_evt;
    logic                     error_evt;
    logic [31:0]              mode_merged;

    // Bus slave front end
    wwd_axil #(
        .AW (8)
    ) u_axil (
        .clk     (CLK_SYS),
        .rst_n   (RST_B),
        .awvalid (S_AXI_AWVALID),
        .awready (S_AXI_AWREADY),
        .awaddr  (S_AXI_AWADDR),
        .wvalid  (S_AXI_WVALID),
        .wready  (S_AXI_WREADY),
        .wdata   (S_AXI_WDATA),
        .wstrb   (S_AXI_WSTRB),
        .bvalid  (S_AXI_BVALID),
        .bready  (S_AXI_BREADY),
        .bresp   (S_AXI_BRESP),
        .arvalid (S_AXI_ARVALID),
        .arready (S_AXI_ARREADY),
        .araddr  (S_AXI_ARADDR),
        .rvalid  (S_AXI_RVALID),
        .rready  (S_AXI_RREADY),
        .rdata   (S_AXI_RDATA),
        .rresp   (S_AXI_RRESP),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // Field decode of the stored mode word
    assign reload_value          = mode_reg[`WWD_RELOAD_MSB:`WWD_RELOAD_LSB];
    assign window_delta          = mode_reg[`WWD_DELTA_MSB:`WWD_DELTA_LSB];
    assign fault_irq_enable      = mode_reg[`WWD_FIEN_BIT];
    assign fault_reset_enable    = mode_reg[`WWD_RSTEN_BIT];
    assign cpu_only_reset_select = mode_reg[`WWD_CPUSEL_BIT];
    assign guard_disable         = mode_reg[`WWD_DIS_BIT];
    assign debug_halt_enable     = mode_reg[`WWD_DBGHLT_BIT];
    assign idle_halt_enable      = mode_reg[`WWD_IDLEHLT_BIT];

    // Access decode; low address bits are ignored so each register is one word
    assign ctrl_wr   = wr_en && (wr_addr[7:2] == idx_control);
    assign mode_wr   = wr_en && (wr_addr[7:2] == idx_mode) && !mode_locked_reg;
    assign status_rd = rd_en && (rd_addr[7:2] == idx_status);

    // Key check: the key byte must be written and match
    assign key_ok      = wr_strb[3] && (wr_data[`WWD_KEY_MSB:`WWD_KEY_LSB] == `WWD_KEY_VALUE);
    assign restart_cmd = ctrl_wr && key_ok && wr_strb[0] && wr_data[`WWD_RESTART_BIT];

    // Window test; a delta at or above reload opens the whole range
    assign window_open = (window_delta >= reload_value)
                      || (count_reg <= window_delta);

    // Restart outcome, independent of the disable bit
    always_comb begin
        restart_kind = wwd_pkg::WWD_RS_NONE;
        if (restart_cmd) begin
            if (window_open) begin
                restart_kind = wwd_pkg::WWD_RS_RELOAD;
            end else begin
                restart_kind = wwd_pkg::WWD_RS_ERROR;
            end
        end
    end

    // Byte-lane merge of a mode write over the current value
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign mode_merged[b*8 +: 8] = wr_strb[b] ? wr_data[b*8 +: 8] : mode_reg[b*8 +: 8];
        end
    endgenerate

    // Next mode word: only the first write after reset lands
    always_comb begin
        mode_next = mode_reg;
        if (mode_wr) begin
            mode_next = mode_merged & `WWD_MODE_WMASK;
        end
    end

    // Any reload clears the prescaler and takes the freshest reload value
    assign reload_now = (restart_kind == wwd_pkg::WWD_RS_RELOAD) || mode_wr;
    assign reload_src = mode_wr ? mode_next[`WWD_RELOAD_MSB:`WWD_RELOAD_LSB] : reload_value;

    // Run gating by disable, debug and idle halts
    assign halted  = (debug_halt_enable && CPU_DEBUG)
                  || (idle_halt_enable && SYS_IDLE);
    assign running = !guard_disable && !halted;

    // Prescaler; slow ticks only count while running
    wwd_presc #(
        .DIV (PRESCALE_DIV)
    ) u_presc (
        .clk   (CLK_SYS),
        .rst_n (RST_B),
        .clr   (reload_now),
        .en    (running && SLOW_TICK),
        .step  (step)
    );

    // Events
    assign underflow_evt = step && (count_reg == '0);
    assign error_evt     = (restart_kind == wwd_pkg::WWD_RS_ERROR);

    // Counter next value: reloads beat steps, underflow wraps to the reload value
    always_comb begin
        count_next = count_reg;
        if (reload_now) begin
            count_next = reload_src;
        end else if (underflow_evt) begin
            count_next = reload_value;
        end else if (step) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Sticky flags: a status read clears, an event in the same cycle wins
    always_comb begin
        underflow_flag_next    = underflow_flag_reg;
        window_error_flag_next = window_error_flag_reg;
        if (status_rd) begin
            underflow_flag_next    = 1'b0;
            window_error_flag_next = 1'b0;
        end
        if (underflow_evt) begin
            underflow_flag_next = 1'b1;
        end
        if (error_evt) begin
            window_error_flag_next = 1'b1;
        end
    end

    // Mode register and its write-once lock
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            mode_reg        <= `WWD_MODE_RESET;
            mode_locked_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            if (wr_en && (wr_addr[7:2] == idx_mode)) begin
                mode_locked_reg <= 1'b1;
            end
        end
    end

    // Down counter
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            count_reg <= `WWD_CNT_WIDTH'('1);
        end else begin
            count_reg <= count_next;
        end
    end

    // Status flags; a watchdog reset arrives as RST_B and clears them
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            underflow_flag_reg    <= 1'b0;
            window_error_flag_reg <= 1'b0;
        end else begin
            underflow_flag_reg    <= underflow_flag_next;
            window_error_flag_reg <= window_error_flag_next;
        end
    end

    // Fault line and reset kind toward the reset controller
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            WDT_FAULT          <= 1'b0;
            WDT_FAULT_CPU_ONLY <= 1'b0;
        end else begin
            WDT_FAULT <= fault_reset_enable
                      && (underflow_flag_next || window_error_flag_next);
            WDT_FAULT_CPU_ONLY <= fault_reset_enable && cpu_only_reset_select;
        end
    end

    // Interrupt follows the flags while enabled
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            WDT_IRQ <= 1'b0;
        end else begin
            WDT_IRQ <= fault_irq_enable
                    && (underflow_flag_next || window_error_flag_next);
        end
    end

    // Read data; control reads zero, unmapped offsets answer with an error
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        unique case (rd_addr[7:2])
            idx_control: rd_data = '0;
            idx_mode:    rd_data = mode_reg;
            idx_status: begin
                rd_data[`WWD_UNF_BIT] = underflow_flag_reg;
                rd_data[`WWD_ERR_BIT] = window_error_flag_reg;
            end
            default:               rd_err  = 1'b1;
        endcase
    end

    // Write answer; writes to unmapped offsets answer with an error
    always_comb begin
        wr_err = 1'b0;
        unique case (wr_addr[7:2])
            idx_control,
            idx_mode,
            idx_status:           wr_err = 1'b0;
            default:              wr_err = 1'b1;
        endcase
    end
endmodule
`default_nettype wire

// *** wwd_asserts.sv ***
// Bus timing and fault line assertions for the windowed watchdog
`default_nettype none
module wwd_asserts (
    // Clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RST_B,
    // Bus handshakes
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    // Fault outputs
    input wire logic        WDT_FAULT,
    input wire logic        WDT_IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    logic ar_hs;
    // Read address taken
    assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
    chk_b_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write answer off");
    chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write answer dropped");
    chk_r_answer: assert property (ar_hs |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read answer off");
    chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
        && $stable(S_AXI_RDATA)) else $error("read answer dropped");
    chk_ctrl_zero: assert property (
        ar_hs && S_AXI_ARADDR == 8'h00 |=> !(|S_AXI_RDATA)) else $error("control read");
    chk_status_bits: assert property (
        ar_hs && S_AXI_ARADDR == 8'h08 |=> !(|S_AXI_RDATA[31:2])) else $error("status bits");
    chk_irq_sticky: assert property (
        WDT_IRQ && !(ar_hs && S_AXI_ARADDR == 8'h08) |=> WDT_IRQ) else $error("irq lost");
    chk_rst_quiet: assert property ($rose(RST_B) |-> !WDT_FAULT && !WDT_IRQ)
        else $error("fault after reset");
endmodule
bind wwd_top wwd_asserts i_chk (.*);
`default_nettype wire

// *** wwd_rstc_model.sv ***
// Reset controller model counting watchdog resets by kind
`default_nettype none
module wwd_rstc_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Fault link
    input wire logic fault,
    input wire logic cpu_only,
    // Reset counts
    output var int   cpu_resets,
    output var int   sys_resets
);
    timeunit 1ns;
    timeprecision 1ns;
    logic fault_q;
    // Each new fault asks for the reset kind named by the select line
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_q <= 1'h0;
            cpu_resets <= 0;
            sys_resets <= 0;
        end else begin
            fault_q <= fault;
            if (fault && !fault_q && cpu_only) cpu_resets <= cpu_resets + 1;
            if (fault && !fault_q && !cpu_only) sys_resets <= sys_resets + 1;
        end
    end
endmodule
`default_nettype wire

// *** windowed_watchdog_timer_test.sv ***
// Register level testbench of the windowed watchdog
`default_nettype none
module windowed_watchdog_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_b, tick, awv, wv, bre, arv, rre, awr, wrdy, bv, arr, rv, flt, fcpu, irq;
    logic        dbg, idl;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdd;
    logic [1:0]  br, rr;
    int          fails, num_checks, cpu_rst, sys_rst;
    wwd_top #(.PRESCALE_DIV(2)) i_dut (
        .CLK_SYS(clk), .RST_B(rst_b), .SLOW_TICK(tick), .CPU_DEBUG(dbg), .SYS_IDLE(idl),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bre), .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .S_AXI_RDATA(rdd),
        .S_AXI_RRESP(rr), .WDT_FAULT(flt), .WDT_FAULT_CPU_ONLY(fcpu), .WDT_IRQ(irq));
    wwd_rstc_model i_rstc (.clk(clk), .rst_b(rst_b), .fault(flt), .cpu_only(fcpu),
        .cpu_resets(cpu_rst), .sys_resets(sys_rst));
    // Counts, verdict and end of run
    task give_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task hang();
        fails++;
        $display("FAIL %0t bus wait ran out", $time);
        give_verdict();
    endtask
    task cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task cmp1(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t %s got %b", $time, what, got);
        end
    endtask
    // Bus write: address and data together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awv <= 1'h1;
        wv <= 1'h1;
        awa <= a;
        wd <= d;
        bre <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'h0;
            if (wrdy) wv <= 1'h0;
            n++;
        end while (!bv && n < 50);
        bre <= 1'h0;
        if (n >= 50) hang();
        cmp32({30'h0, br}, 32'h0, "write answer");
    endtask
    // Bus read with expected data and answer
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge clk);
        arv <= 1'h1;
        ara <= a;
        rre <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'h0;
            n++;
        end while (!rv && n < 50);
        rre <= 1'h0;
        if (n >= 50) hang();
        cmp32(rdd, exp, "read data");
        cmp32({30'h0, rr}, {30'h0, er}, "read answer");
    endtask
    // Slow clock pulses, then one edge so their effect is visible
    task ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'h1;
            @(posedge clk);
            tick <= 1'h0;
        end
        @(posedge clk);
    endtask
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst_b, tick, dbg, idl, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
        fails = 0;
        num_checks = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'h1;
        rd(8'h04, 32'h3FFF2FFF, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h0C, 32'h0, 2'h2);
        $display("test reset_values done");
        wr(8'h00, 32'hA5000001);
        rd(8'h08, 32'h0, 2'h0);
        ticks(3);
        wr(8'h04, 32'h00017004);
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h00017004, 2'h0);
        $display("test mode_once done");
        wr(8'h00, 32'h5A000001);
        rd(8'h08, 32'h0, 2'h0);
        wr(8'h00, 32'hA5000001);
        cmp1(flt, 1'h1, "fault on error");
        cmp1(fcpu, 1'h1, "cpu only");
        cmp1(irq, 1'h1, "irq on error");
        rd(8'h08, 32'h2, 2'h0);
        cmp1(irq, 1'h0, "irq after read");
        cmp1(flt, 1'h0, "fault after read");
        rd(8'h08, 32'h0, 2'h0);
        $display("test window_error done");
        ticks(9);
        cmp1(flt, 1'h0, "early underflow");
        ticks(1);
        cmp1(flt, 1'h1, "underflow fault");
        rd(8'h08, 32'h1, 2'h0);
        ticks(6);
        wr(8'h00, 32'hA5000001);
        rd(8'h08, 32'h0, 2'h0);
        ticks(9);
        cmp1(flt, 1'h0, "restart reload");
        ticks(1);
        cmp1(irq, 1'h1, "second underflow");
        @(posedge clk);
        cmp32(cpu_rst, 32'h3, "cpu resets");
        cmp32(sys_rst, 32'h0, "system resets");
        $display("test underflow done");
        rst_b <= 1'h0;
        dbg <= 1'h1;
        @(posedge clk);
        cmp1(flt, 1'h0, "fault in reset");
        rst_b <= 1'h1;
        rd(8'h08, 32'h0, 2'h0);
        wr(8'h04, 32'h30022002);
        ticks(6);
        cmp1(flt, 1'h0, "debug halt");
        {dbg, idl} <= 2'h1;
        ticks(6);
        cmp1(flt, 1'h0, "idle halt");
        idl <= 1'h0;
        ticks(6);
        cmp1(flt, 1'h1, "run after halts");
        cmp1(fcpu, 1'h0, "all resets");
        @(posedge clk);
        cmp32(sys_rst, 32'h1, "system reset");
        $display("test halts done");
        rst_b <= 1'h0;
        @(posedge clk);
        rst_b <= 1'h1;
        wr(8'h04, 32'h0000A002);
        ticks(6);
        cmp1(flt, 1'h0, "disabled");
        wr(8'h00, 32'hA5000001);
        cmp1(flt, 1'h1, "error while disabled");
        $display("test disable done");
        give_verdict();
    end
endmodule
`default_nettype wire
